// ---- logic/pin_sync.sv ----
// two-flop synchroniser for the bus pin levels
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // levels
  input  wire serial_bus_pkg::line_trio_t raw,
  output serial_bus_pkg::line_trio_t      synced
);
  import serial_bus_pkg::*;

  line_trio_t meta;      // first stage, read by second stage only
  line_trio_t next_meta; // next first stage
  line_trio_t next_sync; // next second stage

  // idle bus is high, so reset to released levels
  always_comb begin
    next_meta = raw;
    next_sync = meta;
  end

  // register both stages
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta   <= '1;
      synced <= '1;
    end else begin
      meta   <= next_meta;
      synced <= next_sync;
    end
  end

endmodule : pin_sync

// ---- logic/serial_bus_pkg.sv ----
// constants, types and register map of the two-wire bus mode engine
package serial_bus_pkg;

  // apb word
  typedef logic [31:0] word_t;

  // register byte addresses
  localparam logic [7:0] OFS_CTRL  = 8'h00; // control
  localparam logic [7:0] OFS_SHIFT = 8'h04; // serial_shift_reg
  localparam logic [7:0] OFS_OWN   = 8'h08; // own_address_reg
  localparam logic [7:0] OFS_STAT  = 8'h0c; // status, write one to clear start, stop and wake

  // control field positions
  localparam int CTL_EN         = 0; // channel_enable_bit
  localparam int CTL_WAKE_SEL   = 1; // wake_on_match_select
  localparam int CTL_LINE_B     = 2; // use data_line_b
  localparam int CTL_WAIT_EN    = 3; // insert slave wait each byte, except the ninth-clock wait after a sent byte the master refuses
  localparam int CTL_WAIT_NINTH = 4; // wait after ninth, else eighth
  localparam int CTL_W          = 5;

  // status field positions
  localparam int ST_MATCH = 0; // address_match_flag
  localparam int ST_START = 1; // start_detected_flag
  localparam int ST_STOP  = 2; // stop detected
  localparam int ST_WAKE  = 3; // wake event seen
  localparam int ST_WAIT  = 4; // clock held; write one releases
  localparam int ST_SEL   = 5; // addressed
  localparam int ST_DIR   = 6; // one: slave sends
  localparam int ST_ACK   = 7; // master acked last sent byte

  // reset values
  localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [7:0] SHIFT_RST = 8'hff; // released line
  localparam logic [7:0] OWN_RST   = 8'h00;

  // bit slots within a byte
  localparam logic [3:0] LAST_DATA = 4'h7; // eighth rise is next
  localparam logic [3:0] BYTE_DONE = 4'h8; // eight bits taken
  localparam logic [3:0] ACK_DONE  = 4'h9; // acknowledge taken

  // byte phase of the slave
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_RX, PH_TX, PH_SKIP
  } phase_t;

  // raw or synchronised pin levels
  typedef struct packed {
    logic scl;
    logic sda_a;
    logic sda_b;
  } line_trio_t;

endpackage : serial_bus_pkg

// ---- logic/two_wire_bus_mode_engine.sv ----
// two-wire bus slave engine with apb register access
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module two_wire_bus_mode_engine (
  // clock and reset
  input  wire logic          CLOCK,
  input  wire logic          RST_N,
  // apb slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output serial_bus_pkg::word_t PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // open-drain clock pin
  input  wire logic          SCL_IN,
  output logic               SCL_OUT,
  output logic               SCL_OE,
  // open-drain data pins
  input  wire logic          DATA_A_IN,
  output logic               DATA_A_OUT,
  output logic               DATA_A_OE,
  input  wire logic          DATA_B_IN,
  output logic               DATA_B_OUT,
  output logic               DATA_B_OE,
  // wake request to the processor
  output logic               WAKE_REQ
);
  import serial_bus_pkg::*;

  // decode of a mapped register address
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_SHIFT) ||
             (a == OFS_OWN) || (a == OFS_STAT);
  endfunction : mapped

  line_trio_t       raw;       // pin levels as they arrive
  line_trio_t       cur;       // synchronised levels
  line_trio_t       prev;      // levels one cycle back
  logic [CTL_W-1:0] ctrl;      // control register
  logic [7:0]       shift;     // serial_shift_reg
  logic [7:0]       own;       // own_address_reg
  logic             match;     // address_match_flag
  logic             f_start;   // start_detected_flag
  logic             f_stop;    // stop seen
  logic             f_wake;    // wake seen
  logic             waiting;   // clock held low
  logic             selected;  // addressed slave
  logic             dir;       // slave sends when set
  logic             ack;       // master acked
  phase_t           phase;     // byte phase
  logic [3:0]       cnt;       // clock rises in this byte
  logic             sda_pull;  // pull data line low
  logic             scl_pull;  // pull clock line low
  word_t            rdata;     // registered read data
  logic             wake;      // wake pulse

  logic [CTL_W-1:0] next_ctrl;
  logic [7:0]       next_shift, next_own;
  logic             next_match, next_f_start, next_f_stop, next_f_wake;
  logic             next_waiting, next_selected, next_dir, next_ack;
  phase_t           next_phase;
  logic [3:0]       next_cnt;
  logic             next_sda_pull, next_scl_pull, next_wake;
  word_t            next_rdata;
  line_trio_t       next_prev;

  // bus events seen on synchronised levels
  logic en, sda, sda_old, scl_rise, scl_fall, start_ev, stop_ev, wr, hit;
  logic [7:0] stat;

  assign raw = '{scl: SCL_IN, sda_a: DATA_A_IN, sda_b: DATA_B_IN};

  // pins cross into the clock domain here
  pin_sync u_sync (
    .clk    (CLOCK),
    .rst_n  (RST_N),
    .raw    (raw),
    .synced (cur)
  );

  // edge and condition decode
  always_comb begin
    en       = ctrl[CTL_EN];
    sda      = ctrl[CTL_LINE_B] ? cur.sda_b : cur.sda_a;
    sda_old  = ctrl[CTL_LINE_B] ? prev.sda_b : prev.sda_a;
    scl_rise = cur.scl & ~prev.scl;
    scl_fall = ~cur.scl & prev.scl;
    start_ev = cur.scl & prev.scl & sda_old & ~sda;
    stop_ev  = cur.scl & prev.scl & ~sda_old & sda;
    hit      = (shift[6:0] == own[7:1]);
    wr       = PSEL & PENABLE & PWRITE & mapped(PADDR);
    stat     = {ack, dir, selected, waiting, f_wake, f_stop, f_start,
                match};
  end

  // register and engine next state; hardware sets win over clears
  always_comb begin
    next_ctrl     = ctrl;
    next_shift    = shift;
    next_own      = own;
    next_f_start  = f_start;
    next_f_stop   = f_stop;
    next_f_wake   = f_wake;
    next_waiting  = waiting;
    next_selected = selected;
    next_dir      = dir;
    next_ack      = ack;
    next_phase    = phase;
    next_cnt      = cnt;
    next_sda_pull = sda_pull;
    next_scl_pull = scl_pull;
    next_wake     = 1'b0;
    next_prev     = cur;
    next_rdata    = rdata;
    next_match    = en & (shift == own);
    // read data captured in the setup cycle
    if (PSEL && !PENABLE) begin
      case (PADDR)
        OFS_CTRL:  next_rdata = {27'h0, ctrl};
        OFS_SHIFT: next_rdata = {24'h0, shift};
        OFS_OWN:   next_rdata = {24'h0, own};
        OFS_STAT:  next_rdata = {24'h0, stat};
        default:   next_rdata = 32'h0;
      endcase
    end
    // software writes
    if (wr) begin
      case (PADDR)
        OFS_CTRL:  next_ctrl = PWDATA[CTL_W-1:0];
        OFS_SHIFT: next_shift = PWDATA[7:0];
        OFS_OWN:   next_own = PWDATA[7:0];
        OFS_STAT: begin
          if (PWDATA[ST_START]) next_f_start = 1'b0;
          if (PWDATA[ST_STOP]) next_f_stop = 1'b0;
          if (PWDATA[ST_WAKE]) next_f_wake = 1'b0;
          // release the stretched clock
          if (PWDATA[ST_WAIT] && waiting) begin
            next_waiting  = 1'b0;
            next_scl_pull = 1'b0;
            if (phase == PH_TX && cnt == 4'h0) begin
              next_sda_pull = ~shift[7];
            end
          end
        end
        default: next_ctrl = ctrl;
      endcase
    end
    // engine
    if (!en) begin
      // stopped channel lets go of both lines
      next_phase    = PH_IDLE;
      next_cnt      = 4'h0;
      next_sda_pull = 1'b0;
      next_scl_pull = 1'b0;
      next_waiting  = 1'b0;
      next_selected = 1'b0;
    end else if (start_ev) begin
      next_f_start  = 1'b1;
      next_phase    = PH_ADDR;
      next_cnt      = 4'h0;
      next_selected = 1'b0;
      next_sda_pull = 1'b0;
    end else if (stop_ev) begin
      next_f_stop   = 1'b1;
      next_phase    = PH_IDLE;
      next_selected = 1'b0;
      next_sda_pull = 1'b0;
      next_scl_pull = 1'b0;
      next_waiting  = 1'b0;
      // with wake select only an addressed transfer reports its end
      if (!ctrl[CTL_WAKE_SEL] || selected) begin
        next_wake = 1'b1;
      end
    end else if (phase != PH_IDLE && phase != PH_SKIP) begin
      if (scl_rise) begin
        if (cnt < BYTE_DONE) begin
          // sampling the bus also reads back our own sent bits
          next_shift = {shift[6:0], sda};
          next_cnt   = cnt + 4'h1;
          if (cnt == LAST_DATA && phase == PH_ADDR) begin
            if (hit) begin
              next_selected = 1'b1;
              next_dir      = sda;
              next_wake     = 1'b1;
            end else begin
              next_phase = PH_SKIP;
            end
          end else if (cnt == LAST_DATA && !ctrl[CTL_WAKE_SEL]) begin
            next_wake = 1'b1;
          end
        end else begin
          next_cnt = ACK_DONE;
          if (phase == PH_ADDR) begin
            next_phase = dir ? PH_TX : PH_RX;
          end else if (phase == PH_TX) begin
            next_ack = ~sda;
            // no ack means the master ends it; stay off the bus
            if (sda) next_phase = PH_SKIP;
          end
        end
      end else if (scl_fall) begin
        if (cnt == BYTE_DONE) begin
          // receiver acks, sender lets the line go
          next_sda_pull = (phase != PH_TX);
          if (ctrl[CTL_WAIT_EN] && !ctrl[CTL_WAIT_NINTH]) begin
            next_scl_pull = 1'b1;
            next_waiting  = 1'b1;
          end
        end else if (cnt == ACK_DONE) begin
          next_cnt      = 4'h0;
          next_sda_pull = (phase == PH_TX) & ~shift[7];
          if (ctrl[CTL_WAIT_EN] && ctrl[CTL_WAIT_NINTH]) begin
            next_scl_pull = 1'b1;
            next_waiting  = 1'b1;
          end
        end else if (phase == PH_TX) begin
          next_sda_pull = ~shift[7];
        end
      end
    end
    if (next_wake) next_f_wake = 1'b1;
  end

  // state registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl     <= CTRL_RST;
      shift    <= SHIFT_RST;
      own      <= OWN_RST;
      match    <= 1'b0;
      f_start  <= 1'b0;
      f_stop   <= 1'b0;
      f_wake   <= 1'b0;
      waiting  <= 1'b0;
      selected <= 1'b0;
      dir      <= 1'b0;
      ack      <= 1'b0;
      phase    <= PH_IDLE;
      cnt      <= 4'h0;
      sda_pull <= 1'b0;
      scl_pull <= 1'b0;
      wake     <= 1'b0;
      rdata    <= 32'h0;
      prev     <= '1;
    end else begin
      ctrl     <= next_ctrl;
      shift    <= next_shift;
      own      <= next_own;
      match    <= next_match;
      f_start  <= next_f_start;
      f_stop   <= next_f_stop;
      f_wake   <= next_f_wake;
      waiting  <= next_waiting;
      selected <= next_selected;
      dir      <= next_dir;
      ack      <= next_ack;
      phase    <= next_phase;
      cnt      <= next_cnt;
      sda_pull <= next_sda_pull;
      scl_pull <= next_scl_pull;
      wake     <= next_wake;
      rdata    <= next_rdata;
      prev     <= next_prev;
    end
  end

  // outputs; pins only ever pull low
  assign PRDATA     = rdata;
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL & PENABLE & ~mapped(PADDR);
  assign SCL_OUT    = 1'b0;
  assign SCL_OE     = scl_pull;
  assign DATA_A_OUT = 1'b0;
  assign DATA_B_OUT = 1'b0;
  assign DATA_A_OE  = sda_pull & ~ctrl[CTL_LINE_B];
  assign DATA_B_OE  = sda_pull & ctrl[CTL_LINE_B];
  assign WAKE_REQ   = wake;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  match_flag_a: assert property (en && shift == own |=> match)
    else $error("match flag missed equal bytes");
  start_flag_a: assert property (en && start_ev |=> f_start)
    else $error("start not flagged");
  addr_phase_a: assert property (en && start_ev |=>
      phase == PH_ADDR && cnt == 4'h0)
    else $error("no address phase after start");
  foreign_skip_a: assert property (en && !start_ev && !stop_ev &&
      phase == PH_ADDR && scl_rise && cnt == LAST_DATA && !hit |=>
      phase == PH_SKIP && !selected)
    else $error("foreign address not skipped");
  dir_pick_a: assert property (en && !start_ev && !stop_ev &&
      phase == PH_ADDR && scl_rise && cnt == BYTE_DONE |=>
      phase == ($past(dir) ? PH_TX : PH_RX))
    else $error("direction bit not honoured");
  ack_drive_a: assert property (en && !start_ev && !stop_ev &&
      phase == PH_RX && scl_fall && cnt == BYTE_DONE |=>
      sda_pull ##1 sda_pull)
    else $error("no acknowledge driven");
  stop_flag_a: assert property (en && stop_ev |=>
      f_stop && phase == PH_IDLE && !SCL_OE)
    else $error("stop not handled");
  wait_hold_a: assert property (waiting |-> SCL_OE)
    else $error("wait without clock held");
  match_wake_a: assert property (en && !start_ev && !stop_ev &&
      phase == PH_ADDR && scl_rise && cnt == LAST_DATA && hit
      |=> WAKE_REQ && selected)
    else $error("address match gave no wake");
  stop_wake_a: assert property (en && stop_ev && !ctrl[CTL_WAKE_SEL]
      |=> WAKE_REQ)
    else $error("stop gave no wake");
  one_line_a: assert property (!(DATA_A_OE && DATA_B_OE))
    else $error("both data lines driven");
  msb_out_a: assert property (en && !start_ev && !stop_ev &&
      phase == PH_TX && scl_fall && cnt != 4'h0 && cnt < BYTE_DONE
      |=> sda_pull == !$past(shift[7]))
    else $error("wrong transmit bit");

  sequence match_wake_a_seq;
    phase == PH_ADDR ##1 selected;
  endsequence
  addressed_c: cover property (match_wake_a_seq);
  tx_nack_c: cover property (phase == PH_TX ##1 phase == PH_SKIP);
  wait_rel_c: cover property (waiting ##1 !waiting && en);

endmodule : two_wire_bus_mode_engine

// ---- tb/bus_master_model.sv ----
// two-wire bus master model pulling the open-drain clock and data lines
`timescale 1ns/1ps
module bus_master_model (
  // device clock
  input  wire logic clk,
  // wire levels
  input  wire logic scl,
  input  wire logic sda,
  // pulls, high while pulling the line low
  output logic      scl_oe,
  output logic      sda_oe
);
  localparam int HALF = 4; // cycles per wait step, 100 ns; clock low 8, high 5 cycles

  // lines released until the first frame
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // wait whole device clock cycles
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // release the clock; a slave may hold it low, so wait until it is free
  task automatic free_clock();
    int n;
    scl_oe <= 1'b0;
    tick(1);
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    tick(HALF);
  endtask : free_clock

  // one bit: data set while clock low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    tick(HALF);
    free_clock();
    r = sda;
    scl_oe <= 1'b1;
    tick(HALF);
  endtask : bit_io

  // data falls while clock high, then clock low
  task automatic start_cond();
    sda_oe <= 1'b1;
    tick(HALF);
    scl_oe <= 1'b1;
    tick(HALF);
  endtask : start_cond

  // data rises while clock high
  task automatic stop_cond();
    sda_oe <= 1'b1;
    tick(HALF);
    free_clock();
    sda_oe <= 1'b0;
    tick(2 * HALF);
  endtask : stop_cond

  // eight bits msb first, then listen for the acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : write_byte

  // eight bits in, acknowledge withheld after the last byte
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : read_byte
endmodule : bus_master_model

// ---- tb/two_wire_bus_mode_engine_bench.sv ----
// self-checking bench of the two-wire bus slave engine
`timescale 1ns/1ps
module two_wire_bus_mode_engine_bench;
  import serial_bus_pkg::*;
  // drive of the design inputs
  logic       clock, rst_n, psel, penable, pwrite, use_b;
  logic [7:0] paddr;
  word_t      pwdata, prdata, st_seen, rx_seen;
  // design outputs and wire levels
  logic       pready, pslverr, scl_out, scl_oe, wake;
  logic       da_out, da_oe, db_out, db_oe;
  logic       scl_w, sda_a, sda_b, m_scl, m_sda, bad_pin;
  // bench counters and random seed
  int         n_errors, n_compared, seed, wake_cnt, n_waits;

  // open-drain wires with pull-ups: low while any party pulls
  assign scl_w = ~(m_scl | scl_oe);
  assign sda_a = ~(da_oe | (m_sda & ~use_b));
  assign sda_b = ~(db_oe | (m_sda & use_b));

  always #12.5 clock = ~clock;

  two_wire_bus_mode_engine u_two_wire_bus_mode_engine (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SCL_IN(scl_w),
    .SCL_OUT(scl_out), .SCL_OE(scl_oe), .DATA_A_IN(sda_a),
    .DATA_A_OUT(da_out), .DATA_A_OE(da_oe), .DATA_B_IN(sda_b),
    .DATA_B_OUT(db_out), .DATA_B_OE(db_oe), .WAKE_REQ(wake));

  bus_master_model u_bus_master_model (
    .clk(clock), .scl(scl_w), .sda(use_b ? sda_b : sda_a),
    .scl_oe(m_scl), .sda_oe(m_sda));

  // count wake pulses; pins never driven high, unused line never pulled
  // pins are unknown until the first reset edge, so look only after it
  always @(posedge clock) begin
    if (wake === 1'b1) wake_cnt++;
    if (rst_n === 1'b1 &&
        (scl_out !== 1'b0 || da_out !== 1'b0 || db_out !== 1'b0 ||
         (use_b ? da_oe : db_oe) !== 1'b0)) bad_pin = 1'b1;
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input word_t got, input word_t exp, input string s);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s: got %h, expected %h", $time, s, got, exp);
    end
  endtask : check

  // one apb transfer; waits for pready, bounded
  task automatic apb(input logic [7:0] a, input logic w, input word_t wd,
                     output word_t rd, output logic err);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) check(32'h0, 32'h1, "apb answer");
  endtask : apb

  task automatic wr(input logic [7:0] a, input word_t d);
    word_t r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input word_t m, input word_t x,
                        input string s);
    word_t r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    check(r & m, x, s);
  endtask : rd_chk

  // a whole frame by the master while software polls and lifts waits
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] got, output logic ack_a,
                      output logic ack_d);
    logic  done;
    word_t r;
    logic  e;
    done = 1'b0;
    st_seen = '0;
    rx_seen = '0;
    ack_d = 1'b0;
    got = 8'h00;
    fork
      begin
        u_bus_master_model.start_cond();
        u_bus_master_model.write_byte(a, ack_a);
        if (ack_a && a[0]) u_bus_master_model.read_byte(1'b1, got);
        else if (ack_a) u_bus_master_model.write_byte(d, ack_d);
        u_bus_master_model.stop_cond();
        done = 1'b1;
      end
      while (!done) begin
        apb(OFS_STAT, 1'b0, 32'h0, r, e);
        st_seen |= r;
        if (r[ST_WAIT] === 1'b1) begin
          check(word_t'(scl_oe), 32'h1, "clock held in wait");
          // the stop's clock rise shifts once more, so take the byte here
          if (!a[0]) apb(OFS_SHIFT, 1'b0, 32'h0, rx_seen, e);
          if (a[0]) wr(OFS_SHIFT, {24'h0, d});
          wr(OFS_STAT, 32'h10);
          n_waits++;
        end
      end
    join
    repeat (8) @(posedge clock);
  endtask : xfer

  // main sequence
  initial begin
    logic [7:0] ofs [3];
    word_t      msk [3];
    word_t      v, r;
    logic [6:0] a7;
    logic [7:0] d, got;
    logic       e, ack_a, ack_d;
    ofs = '{OFS_CTRL, OFS_SHIFT, OFS_OWN};
    msk = '{32'h1f, 32'hff, 32'hff};
    clock = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = '0;
    use_b = 1'b0;
    bad_pin = 1'b0;
    seed = 73;
    n_errors = 0;
    n_compared = 0;
    wake_cnt = 0;
    n_waits = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, unmapped place, write and read back
    rd_chk(OFS_CTRL, '1, {27'h0, CTRL_RST}, "ctrl reset");
    rd_chk(OFS_SHIFT, '1, {24'h0, SHIFT_RST}, "shift reset");
    rd_chk(OFS_OWN, '1, {24'h0, OWN_RST}, "own reset");
    rd_chk(OFS_STAT, '1, 32'h0, "status reset");
    apb(8'h10, 1'b1, 32'hffffffff, r, e);
    check(word_t'(e), 32'h1, "unmapped write error");
    apb(8'h10, 1'b0, 32'h0, r, e);
    check(r, 32'h0, "unmapped read data");
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      wr(ofs[i], v);
      rd_chk(ofs[i], '1, v & msk[i], "register read back");
    end
    $display("test registers done");
    // match flag as a plain compare of shift and own
    v = $random(seed) & 32'hff;
    wr(OFS_SHIFT, v);
    wr(OFS_OWN, v);
    wr(OFS_CTRL, 32'h01);
    rd_chk(OFS_STAT, 32'h1, 32'h1, "match on equal");
    wr(OFS_SHIFT, v ^ 32'h1);
    rd_chk(OFS_STAT, 32'h1, 32'h0, "match on differ");
    $display("test match flag done");
    // addressed write on line a, wait after the eighth clock
    a7 = $random(seed);
    d = $random(seed);
    wr(OFS_OWN, {24'h0, a7, 1'b0});
    wr(OFS_CTRL, 32'h0b);
    wr(OFS_STAT, 32'hff);
    wake_cnt = 0;
    xfer({a7, 1'b0}, d, got, ack_a, ack_d);
    check(word_t'(ack_a), 32'h1, "address ack");
    check(word_t'(ack_d), 32'h1, "data ack");
    check(rx_seen & 32'hff, {24'h0, d}, "received byte");
    check(word_t'(wake_cnt), 32'h2, "wake count write");
    check(st_seen & 32'h62, 32'h22, "start, selected, dir");
    check(word_t'(n_waits > 0), 32'h1, "eighth wait seen");
    rd_chk(OFS_STAT, 32'h6, 32'h6, "start and stop flags");
    wr(OFS_STAT, 32'hff);
    rd_chk(OFS_STAT, 32'h6, 32'h0, "flags cleared");
    $display("test write frame done");
    // addressed read on line b, wait after the ninth clock
    use_b <= 1'b1;
    wr(OFS_CTRL, 32'h1f);
    d = $random(seed);
    wake_cnt = 0;
    n_waits = 0;
    xfer({a7, 1'b1}, d, got, ack_a, ack_d);
    check(word_t'(ack_a), 32'h1, "read address ack");
    check({24'h0, got}, {24'h0, d}, "sent byte");
    check(st_seen & 32'h40, 32'h40, "dir seen");
    check(word_t'(n_waits > 0), 32'h1, "ninth wait seen");
    check(word_t'(wake_cnt), 32'h2, "wake count read");
    $display("test read frame done");
    // other address, with wake select set and clear
    use_b <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CTRL, s ? 32'h03 : 32'h01);
      wr(OFS_STAT, 32'hff);
      wake_cnt = 0;
      xfer({a7 ^ 7'h01, 1'b0}, d, got, ack_a, ack_d);
      check(word_t'(ack_a), 32'h0, "no ack on other");
      check(st_seen & 32'h20, 32'h0, "not selected");
      check(word_t'(s ? wake_cnt == 0 : wake_cnt >= 1), 32'h1,
            "wake on other");
      rd_chk(OFS_STAT, 32'h4, 32'h4, "stop flag");
    end
    check(word_t'(bad_pin), 32'h0, "open-drain pins");
    $display("test other address done");
    stop_test();
  end

  // cut a hang short
  initial begin
    #1500000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule : two_wire_bus_mode_engine_bench
